/* File: logic/charger_cfg_pkg.sv */
// Package for the charger configuration register bank: offsets, masks,
// reset values, field positions, timer figures and the decoded carrier.
// Assumes one 125 MHz system clock and byte-wide register access.
package charger_cfg_pkg;

    // Register offsets
    localparam logic [7:0] OFS_PRECHG_TERM = 8'h03;
    localparam logic [7:0] OFS_CHG_VOLT    = 8'h04;
    localparam logic [7:0] OFS_TERM_TIMER  = 8'h05;
    localparam logic [7:0] OFS_BOOST_THERM = 8'h06;

    // Reset values
    localparam logic [7:0] RST_PRECHG_TERM = 8'h11;
    localparam logic [7:0] RST_CHG_VOLT    = 8'hB2;
    localparam logic [7:0] RST_TERM_TIMER  = 8'h9A;
    localparam logic [7:0] RST_BOOST_THERM = 8'h93;

    // Writable bits; reserved bits of the timer register stay zero
    localparam logic [7:0] WMASK_TERM_TIMER = 8'hBE;
    localparam logic [7:0] READ_UNMAPPED    = 8'h00;

    // Field positions
    localparam int PRECHG_LSB   = 4;
    localparam int END_CUR_LSB  = 0;
    localparam int VOLT_LSB     = 2;
    localparam int EXIT_SEL_BIT = 1;
    localparam int RECHG_BIT    = 0;
    localparam int EN_TERM_BIT  = 7;
    localparam int KEEP_LSB     = 4;
    localparam int EN_TIMER_BIT = 3;
    localparam int CHG_TMO_LSB  = 1;
    localparam int BOOST_LSB    = 4;
    localparam int HOT_SEL_LSB  = 2;
    localparam int TEMP_REG_LSB = 0;

    // Field codes
    localparam logic [1:0] KEEP_OFF     = 2'h0;
    localparam logic [1:0] KEEP_40S     = 2'h1;
    localparam logic [1:0] KEEP_80S     = 2'h2;
    localparam logic [1:0] HOT_AT_33    = 2'h0;
    localparam logic [1:0] HOT_AT_36    = 2'h1;
    localparam logic [1:0] HOT_AT_30    = 2'h2;
    localparam logic [1:0] HOT_OFF      = 2'h3;
    localparam logic [1:0] CHG_TMO_5H   = 2'h0;
    localparam logic [1:0] CHG_TMO_8H   = 2'h1;
    localparam logic [1:0] CHG_TMO_12H  = 2'h2;
    localparam logic [1:0] FAULT_TIMER  = 2'h3;
    localparam logic [1:0] FAULT_NORMAL = 2'h0;

    // Timing: clock rate, time base and timer lengths
    localparam int CLK_HZ          = 125_000_000;
    localparam int TICK_MS         = 1;
    localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int MS_PER_SEC      = 1000;
    localparam int KEEP_40S_SEC    = 40;
    localparam int KEEP_80S_SEC    = 80;
    localparam int KEEP_160S_SEC   = 160;
    localparam int SEC_PER_HOUR    = 3600;
    localparam int CHG_5H          = 5;
    localparam int CHG_8H          = 8;
    localparam int CHG_12H         = 12;
    localparam int CHG_20H         = 20;

    // Decoded settings handed to the analog control loops
    typedef struct packed {
        logic [3:0] precharge_current_code;
        logic [3:0] end_current_code;
        logic [5:0] charge_voltage_code;
        logic       precharge_exit_threshold_sel;
        logic       recharge_offset_sel;
        logic       termination_en;
        logic [1:0] keepalive_period_sel;
        logic       safety_timer_en;
        logic [1:0] fast_charge_timeout_sel;
        logic [3:0] boost_voltage_code;
        logic [1:0] boost_hot_sel;
        logic [1:0] thermal_regulation_threshold;
    } charge_cfg_s;

endpackage

/* File: logic/charger_config_register_bank.sv */
// Charger configuration register bank with keep-alive and safety timers.
// Assumes the serial bus engine outside presents completed byte writes and
// reads as one-cycle strobes, synchronous to ref_clk.
// What this block does
// RULE1 - Pre-charge current code bits 7:4, reset 0001
// RULE2 - Termination current code bits 3:0, reset 0001
// RULE3 - Charge voltage code bits 7:2, reset 4.208V
// RULE4 - Bit 1 picks precharge exit 2.8/3.0V
// RULE5 - Bit 0 picks recharge offset 100/300mV
// RULE6 - Termination enable bit 7, reset enabled
// RULE7 - Keep-alive period off/40/80/160 s, reset 40s
// RULE8 - Safety timer enable and 5/8/12/20h timeout
// RULE9 - Boost voltage code bits 7:4, reset 1001
// RULE10 - Boost hot threshold 33/36/30 percent or off
// RULE11 - Threshold off still flags thermistor at 33 percent
// RULE12 - Thermal regulation 60/80/100/120 C, reset 120C
// RULE13 - Host spaces keep-alive restarts by 20 us
// RULE14 - Keep-alive expiry sets a latched fault flag
// RULE15 - Safety timer expiry reports charge fault 11
// RULE16 - Reserved bits ignore writes, read fixed value
// RULE17 - Decoded fields presented continuously to control
module charger_config_register_bank #(
    parameter int TICK_CYCLES = charger_cfg_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        srst,
    // Register access from the serial bus engine
    input  wire logic                        wr_en,
    input  wire logic                        rd_en,
    input  wire logic [7:0]                  addr,
    input  wire logic [7:0]                  wr_data,
    output logic      [7:0]                  rd_data,
    output logic                             rd_valid,
    // Charger status and fault handshake
    input  wire logic                        keepalive_kick,
    input  wire logic                        fast_charging,
    input  wire logic                        boost_mode,
    input  wire logic                        fault_clear,
    // Thermistor comparators: high when below 33/36/30 percent of rail
    input  wire logic                        ts_below_33,
    input  wire logic                        ts_below_36,
    input  wire logic                        ts_below_30,
    // Decoded settings and faults
    output charger_cfg_pkg::charge_cfg_s     cfg,
    output logic                             keepalive_expired,
    output logic      [1:0]                  charge_fault_code,
    output logic                             thermistor_fault,
    output logic                             boost_hot_shutdown
);

    logic [7:0]  prechg_term_reg;
    logic [7:0]  chg_volt_reg;
    logic [7:0]  term_timer_reg;
    logic [7:0]  boost_therm_reg;
    logic [16:0] tick_cnt_reg;
    logic [9:0]  ms_cnt_reg;
    logic        ms_tick;
    logic        sec_tick;
    logic [7:0]  keep_sec_reg;
    logic [7:0]  keep_limit;
    logic [16:0] chg_sec_reg;
    logic [16:0] chg_limit;
    logic        keep_restart;
    logic        keep_fire;
    logic        chg_fire;
    logic        hot_sel;

    // Register writes; the timer register drops writes to reserved bits
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            prechg_term_reg <= charger_cfg_pkg::RST_PRECHG_TERM;  // [RULE1] [RULE2]
            chg_volt_reg    <= charger_cfg_pkg::RST_CHG_VOLT;     // [RULE3] [RULE4] [RULE5]
            term_timer_reg  <= charger_cfg_pkg::RST_TERM_TIMER;   // [RULE6] [RULE7] [RULE8]
            boost_therm_reg <= charger_cfg_pkg::RST_BOOST_THERM;  // [RULE9] [RULE10] [RULE12]
        end
        else if (wr_en)
        begin
            case (addr)
                charger_cfg_pkg::OFS_PRECHG_TERM: prechg_term_reg <= wr_data;
                charger_cfg_pkg::OFS_CHG_VOLT:    chg_volt_reg    <= wr_data;
                charger_cfg_pkg::OFS_TERM_TIMER:
                    term_timer_reg <= wr_data & charger_cfg_pkg::WMASK_TERM_TIMER;  // [RULE16]
                charger_cfg_pkg::OFS_BOOST_THERM: boost_therm_reg <= wr_data;
                default: ;
            endcase
        end
    end

    // Read port: data registered, valid one cycle after the strobe
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            rd_data  <= charger_cfg_pkg::READ_UNMAPPED;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= rd_en;
            if (rd_en)
            begin
                case (addr)
                    charger_cfg_pkg::OFS_PRECHG_TERM: rd_data <= prechg_term_reg;
                    charger_cfg_pkg::OFS_CHG_VOLT:    rd_data <= chg_volt_reg;
                    charger_cfg_pkg::OFS_TERM_TIMER:  rd_data <= term_timer_reg;  // [RULE16]
                    charger_cfg_pkg::OFS_BOOST_THERM: rd_data <= boost_therm_reg;
                    default:                          rd_data <= charger_cfg_pkg::READ_UNMAPPED;
                endcase
            end
        end
    end

    // Decoded fields straight from the registers, live the cycle after a write
    always_comb
    begin
        cfg.precharge_current_code       = prechg_term_reg[charger_cfg_pkg::PRECHG_LSB +: 4];  // [RULE1]
        cfg.end_current_code             = prechg_term_reg[charger_cfg_pkg::END_CUR_LSB +: 4]; // [RULE2]
        cfg.charge_voltage_code          = chg_volt_reg[charger_cfg_pkg::VOLT_LSB +: 6];       // [RULE3]
        cfg.precharge_exit_threshold_sel = chg_volt_reg[charger_cfg_pkg::EXIT_SEL_BIT];        // [RULE4]
        cfg.recharge_offset_sel          = chg_volt_reg[charger_cfg_pkg::RECHG_BIT];           // [RULE5]
        cfg.termination_en               = term_timer_reg[charger_cfg_pkg::EN_TERM_BIT];       // [RULE6]
        cfg.keepalive_period_sel         = term_timer_reg[charger_cfg_pkg::KEEP_LSB +: 2];     // [RULE7]
        cfg.safety_timer_en              = term_timer_reg[charger_cfg_pkg::EN_TIMER_BIT];      // [RULE8]
        cfg.fast_charge_timeout_sel      = term_timer_reg[charger_cfg_pkg::CHG_TMO_LSB +: 2];  // [RULE8]
        cfg.boost_voltage_code           = boost_therm_reg[charger_cfg_pkg::BOOST_LSB +: 4];   // [RULE9]
        cfg.boost_hot_sel                = boost_therm_reg[charger_cfg_pkg::HOT_SEL_LSB +: 2]; // [RULE10]
        cfg.thermal_regulation_threshold = boost_therm_reg[charger_cfg_pkg::TEMP_REG_LSB +: 2]; // [RULE12]
    end

    // Millisecond and second time base; one counter chain serves both timers
    assign ms_tick  = (tick_cnt_reg == 17'(TICK_CYCLES - 1));
    assign sec_tick = ms_tick && (ms_cnt_reg == 10'(charger_cfg_pkg::MS_PER_SEC - 1));

    always_ff @(posedge ref_clk)
    begin
        if (srst || ms_tick)
            tick_cnt_reg <= '0;
        else
            tick_cnt_reg <= tick_cnt_reg + 17'h00001;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst || sec_tick)
            ms_cnt_reg <= '0;
        else if (ms_tick)
            ms_cnt_reg <= ms_cnt_reg + 10'h001;
    end

    // Keep-alive limit in seconds
    always_comb
    begin
        case (cfg.keepalive_period_sel)
            charger_cfg_pkg::KEEP_40S: keep_limit = 8'(charger_cfg_pkg::KEEP_40S_SEC);  // [RULE7]
            charger_cfg_pkg::KEEP_80S: keep_limit = 8'(charger_cfg_pkg::KEEP_80S_SEC);
            default:                   keep_limit = 8'(charger_cfg_pkg::KEEP_160S_SEC);
        endcase
    end

    // Kick restarts the count; the host keeps kicks 20 us apart, so none merge
    assign keep_restart = keepalive_kick
                       || (cfg.keepalive_period_sel == charger_cfg_pkg::KEEP_OFF);  // [RULE13]
    // Compare is >= so a period shortened mid-count fires at the next second tick instead of wrapping
    assign keep_fire    = sec_tick && !keep_restart && (keep_sec_reg >= keep_limit - 8'h01);

    always_ff @(posedge ref_clk)
    begin
        if (srst || keep_restart || keep_fire)
            keep_sec_reg <= '0;
        else if (sec_tick)
            keep_sec_reg <= keep_sec_reg + 8'h01;
    end

    // Latched keep-alive fault; a new expiry wins over a clear in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            keepalive_expired <= 1'b0;
        else if (keep_fire)
            keepalive_expired <= 1'b1;  // [RULE14]
        else if (fault_clear)
            keepalive_expired <= 1'b0;
    end

    // Fast-charge timeout in seconds
    always_comb
    begin
        case (cfg.fast_charge_timeout_sel)
            charger_cfg_pkg::CHG_TMO_5H:
                chg_limit = 17'(charger_cfg_pkg::CHG_5H * charger_cfg_pkg::SEC_PER_HOUR);
            charger_cfg_pkg::CHG_TMO_8H:
                chg_limit = 17'(charger_cfg_pkg::CHG_8H * charger_cfg_pkg::SEC_PER_HOUR);
            charger_cfg_pkg::CHG_TMO_12H:
                chg_limit = 17'(charger_cfg_pkg::CHG_12H * charger_cfg_pkg::SEC_PER_HOUR);
            default:
                chg_limit = 17'(charger_cfg_pkg::CHG_20H * charger_cfg_pkg::SEC_PER_HOUR);
        endcase
    end

    // Safety timer runs only in fast charge with the timer enabled
    assign chg_fire = sec_tick && fast_charging && cfg.safety_timer_en
                   && (chg_sec_reg >= chg_limit - 17'h00001);

    always_ff @(posedge ref_clk)
    begin
        if (srst || !fast_charging || !cfg.safety_timer_en || chg_fire)
            chg_sec_reg <= '0;
        else if (sec_tick)
            chg_sec_reg <= chg_sec_reg + 17'h00001;
    end

    // Charge fault code latched until cleared; expiry wins over clear
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            charge_fault_code <= charger_cfg_pkg::FAULT_NORMAL;
        else if (chg_fire)
            charge_fault_code <= charger_cfg_pkg::FAULT_TIMER;  // [RULE15]
        else if (fault_clear)
            charge_fault_code <= charger_cfg_pkg::FAULT_NORMAL;
    end

    // Boost hot comparator selection; code 11 keeps the 33 percent flag only
    always_comb
    begin
        case (cfg.boost_hot_sel)
            charger_cfg_pkg::HOT_AT_36: hot_sel = ts_below_36;   // [RULE10]
            charger_cfg_pkg::HOT_AT_30: hot_sel = ts_below_30;
            default:                    hot_sel = ts_below_33;   // [RULE11]
        endcase
    end

    // Registered so the analog side sees glitch-free levels
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            thermistor_fault   <= 1'b0;
            boost_hot_shutdown <= 1'b0;
        end
        else
        begin
            thermistor_fault   <= boost_mode && hot_sel;  // [RULE11]
            boost_hot_shutdown <= boost_mode && hot_sel
                && (cfg.boost_hot_sel != charger_cfg_pkg::HOT_OFF);  // [RULE10] [RULE17]
        end
    end

endmodule

/* File: test/charger_cfg_assertions.sv */
// Checker for the charger configuration register bank, bound onto its ports.
// Assumes the single ref_clk domain and the synchronous srst of the bank.
module charger_cfg_assertions (
    // Clock and reset
    input wire logic                         ref_clk,
    input wire logic                         srst,
    // Register access
    input wire logic                         wr_en,
    input wire logic [7:0]                   addr,
    input wire logic [7:0]                   wr_data,
    input wire logic [7:0]                   rd_data,
    input wire logic                         rd_valid,
    // Status inputs and decoded outputs
    input wire logic                         boost_mode,
    input wire logic                         fault_clear,
    input wire logic                         ts_below_33,
    input wire charger_cfg_pkg::charge_cfg_s cfg,
    input wire logic                         keepalive_expired,
    input wire logic                         thermistor_fault,
    input wire logic                         boost_hot_shutdown
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    // Each write lands in the decoded fields at the edge that takes it
    a_curr_write: assert property (
        wr_en && addr == 8'h03 |=> cfg[29:22] == $past(wr_data))
        else $error("current codes do not follow the write");
    a_volt_write: assert property (
        wr_en && addr == 8'h04 |=> cfg[21:14] == $past(wr_data))
        else $error("voltage fields do not follow the write");
    a_timer_write: assert property (
        wr_en && addr == 8'h05 |=> cfg[13:8] == {$past(wr_data[7]), $past(wr_data[5:1])})
        else $error("timer fields do not follow the write");
    a_boost_write: assert property (
        wr_en && addr == 8'h06 |=> cfg[7:0] == $past(wr_data))
        else $error("boost fields do not follow the write");
    // Without a write the settings must not drift
    a_cfg_hold: assert property (
        !wr_en |=> $stable(cfg))
        else $error("settings changed without a write");
    // Reserved timer bits always read as zero
    a_timer_reserved: assert property (
        rd_valid && $past(addr) == 8'h05 |-> rd_data[6] == 1'b0 && rd_data[0] == 1'b0)
        else $error("reserved timer bits read as one");
    // Protection off still reports the 33 percent comparator
    a_bhot_off_fault: assert property (
        cfg.boost_hot_sel == 2'h3
        |=> !boost_hot_shutdown && thermistor_fault == $past(boost_mode && ts_below_33))
        else $error("thermal protection off misbehaves");
    // The expiry flag stays until cleared
    a_ka_latched: assert property (
        keepalive_expired && !fault_clear |=> keepalive_expired)
        else $error("keep-alive flag dropped on its own");
endmodule

/* File: test/host_bus_model.sv */
// Host side of the register bus: one-cycle byte strobes and keep-alive kicks.
// Assumes the bank answers a read exactly one cycle after the strobe.
module host_bus_model (
    // Clock
    input  wire logic       ref_clk,
    // Read answer from the bank
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    // Requests to the bank
    output logic            wr_en,
    output logic            rd_en,
    output logic      [7:0] addr,
    output logic      [7:0] wr_data,
    output logic            kick
);
    timeunit 1ns;
    timeprecision 1ps;
    longint last_kick = -20000;

    // Idle bus at time zero
    initial
    begin
        wr_en = 0;
        rd_en = 0;
        kick = 0;
        addr = 8'h00;
        wr_data = 8'h00;
    end

    // Random idle gap models a slow host; released lines show the inverse
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        repeat ($urandom % 3) @(posedge ref_clk);
        @(posedge ref_clk);
        #1 wr_en = 1;
        addr = a;
        wr_data = d;
        @(posedge ref_clk);
        #1 wr_en = 0;
        addr = ~a;
        wr_data = ~d;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge ref_clk);
        #1 rd_en = 1;
        addr = a;
        @(posedge ref_clk);
        #1 rd_en = 0;
        addr = ~a;
        ok = rd_valid;
        d = rd_data;
    endtask

    // Kicks too close together would be lost by the real device
    task automatic kick_timer();
        do
            @(posedge ref_clk);
        while ($time < last_kick + 20000);
        #1 kick = 1;
        @(posedge ref_clk);
        #1 kick = 0;
        last_kick = $time;
    endtask
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the charger configuration register bank.
// Assumes host_bus_model drives the bus; the timer tick is shortened to 1 cycle.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                         ref_clk = 0, srst = 1, kick, ok, rd_valid, ka_exp;
    logic                         fast_charging = 0, boost_mode = 0, fault_clear = 0;
    logic                         wr_en, rd_en, t_fault, b_shut;
    logic [7:0]                   addr, wr_data, rd_data, mem [3:6];
    logic [2:0]                   ts = 0;
    logic [1:0]                   code;
    charger_cfg_pkg::charge_cfg_s cfg;
    int                           errors = 0, checks_done = 0, n;

    always #4 ref_clk = ~ref_clk;

    charger_config_register_bank #(.TICK_CYCLES(1)) dut (
        .ref_clk, .srst, .wr_en, .rd_en, .addr, .wr_data, .rd_data, .rd_valid,
        .keepalive_kick(kick), .fast_charging, .boost_mode, .fault_clear,
        .ts_below_33(ts[0]), .ts_below_36(ts[1]), .ts_below_30(ts[2]), .cfg,
        .keepalive_expired(ka_exp), .charge_fault_code(code),
        .thermistor_fault(t_fault), .boost_hot_shutdown(b_shut));
    host_bus_model host (.ref_clk, .rd_data, .rd_valid, .wr_en, .rd_en, .addr, .wr_data, .kick);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Write, mirror into the expected image, then compare decoded settings
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.write_reg(a, d);
        if (a == 8'h05)
            mem[a] = d & 8'hBE;
        else if (a >= 8'h03 && a <= 8'h06)
            mem[a] = d;
        check(cfg, {mem[3], mem[4], mem[5][7], mem[5][5:1], mem[6]});
    endtask

    // Unmapped offsets read as zero
    task automatic rd(input logic [7:0] a);
        logic [7:0] d;
        host.read_reg(a, d, ok);
        check(ok, 1);
        check(d, (a >= 8'h03 && a <= 8'h06) ? mem[a] : 8'h00);
    endtask

    task automatic clear_faults();
        fault_clear = 1;
        @(posedge ref_clk);
        #1 fault_clear = 0;
        check(ka_exp, 0);
    endtask

    // Expected image of the four registers after any reset
    task automatic load_defaults();
        mem[3] = 8'h11;
        mem[4] = 8'hB2;
        mem[5] = 8'h9A;
        mem[6] = 8'h93;
    endtask

    // Comparator picked by the hot-threshold code; code 11 falls back to 33 percent
    function automatic logic exp_tf(input int i);
        exp_tf = (i >> 3) == 1 ? i[1] : (i >> 3) == 2 ? i[2] : i[0];
    endfunction

    initial
    begin
        void'($urandom(32'h54C3B0AB));
        load_defaults();
        repeat (8) @(posedge ref_clk);
        #1 srst = 0;
        for (int a = 2; a < 8; a++)
            rd(8'(a));
        for (int i = 0; i < 46; i++)
        begin
            n = (i < 6) ? 8'hFF * (i % 2) : $urandom;
            wr(8'(2 + (i < 6 ? 5 - i : $urandom % 6)), 8'(n));
            rd(8'(2 + $urandom % 6));
        end
        boost_mode = 1;
        for (int i = 0; i < 32; i++)
        begin
            wr(8'h06, {mem[6][7:4], 2'(i >> 3), mem[6][1:0]});
            ts = 3'(i);
            repeat (2) @(posedge ref_clk);
            #1 check(t_fault, exp_tf(i));
            check(b_shut, exp_tf(i) && (i >> 3) != 3);
        end
        wr(8'h05, 8'h9A);
        clear_faults();
        host.kick_timer();
        n = 0;
        while (ka_exp !== 1'b1 && n < 42000)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        check(ka_exp, 1);
        check(n >= 39000 && n <= 41000, 1);
        check(code, 2'h0);
        // Mid-run reset with the flag set: flags and registers return to defaults
        srst = 1;
        repeat (2) @(posedge ref_clk);
        #1 srst = 0;
        check(ka_exp, 0);
        check(b_shut, 0);
        check(rd_valid, 0);
        load_defaults();
        for (int a = 3; a < 7; a++)
            rd(8'(a));
        clear_faults();
        end_of_test();
    end
endmodule

bind charger_config_register_bank charger_cfg_assertions chk (.ref_clk, .srst, .wr_en, .addr,
    .wr_data, .rd_data, .rd_valid, .boost_mode, .fault_clear, .ts_below_33, .cfg,
    .keepalive_expired, .thermistor_fault, .boost_hot_shutdown);
